// ### tone_output.sv
// Buzzer tone output controller with its control, port direction and port latch registers
`timescale 1ns/1ps
module tone_output
    import tone_pkg::*;
(
    input  wire logic     sys_clk,      // 25 MHz peripheral clock
    input  wire logic     rstn,         // Asynchronous reset, active low
    input  wire cpu_req_t req,          // CPU register request
    output logic [7:0]    rdata,        // Registered read data
    output logic [7:0]    p3_out,       // Port 3 pin output levels
    output logic [7:0]    p3_oe_n       // Port 3 output enables, low drives
);

    logic [7:0] buzzer_control_ff;
    logic [7:0] port3_direction_ff;
    logic [7:0] port3_latch_ff;
    logic [7:0] rdata_ff;
    logic [7:0] p3_out_ff;
    logic [7:0] p3_oe_n_ff;
    logic       tone_raw;
    logic       tone_output_enable;
    logic [1:0] tone_sel;
    logic       ctrl_hit;
    logic       dir_hit;
    logic       latch_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    assign ctrl_hit           = (req.addr == CTRL_ADDR);
    assign dir_hit            = (req.addr == DIR_ADDR);
    assign latch_hit          = (req.addr == LATCH_ADDR);
    assign tone_output_enable = buzzer_control_ff[EN_BIT];
    assign tone_sel           = {buzzer_control_ff[SEL_HI_BIT], buzzer_control_ff[SEL_LO_BIT]};

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    // Control register; the mask keeps the unused low bits at zero
    // Select may be rewritten while running; the ratio then jumps mid-period
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            buzzer_control_ff <= CTRL_RST;
        else if (ctrl_hit)
            buzzer_control_ff <= apply_write(buzzer_control_ff, req) & CTRL_MASK;
    end

    // Port 3 direction, all inputs after reset
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            port3_direction_ff <= DIR_RST;
        else if (dir_hit)
            port3_direction_ff <= apply_write(port3_direction_ff, req);
    end

    // Port 3 output latch
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            port3_latch_ff <= LATCH_RST;
        else if (latch_hit)
            port3_latch_ff <= apply_write(port3_latch_ff, req);
    end

    // Read port; unmapped addresses return zero
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_ff <= 8'h00;
        else if (req.rd && ctrl_hit)
            rdata_ff <= buzzer_control_ff;
        else if (req.rd && dir_hit)
            rdata_ff <= port3_direction_ff;
        else if (req.rd && latch_hit)
            rdata_ff <= port3_latch_ff;
        else if (req.rd)
            rdata_ff <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divider

    tone_divider #(
        .W      (DIV_W)
    ) u_div (
        .sys_clk(sys_clk),
        .rstn   (rstn),
        .enable (tone_output_enable),
        .sel    (tone_sel),
        .tone   (tone_raw)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pins

    // Tone is ORed with the pin 3 latch bit, so setting that bit masks the buzzer
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            p3_out_ff <= LATCH_RST;
        else
        begin
            p3_out_ff           <= port3_latch_ff;
            p3_out_ff[TONE_PIN] <= port3_latch_ff[TONE_PIN] | tone_raw;
        end
    end

    // Only pins 1 to 4 have an output buffer; the rest stay released
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            p3_oe_n_ff <= 8'hff;
        else
        begin
            p3_oe_n_ff                      <= 8'hff;
            p3_oe_n_ff[PIN_LAST:PIN_FIRST]  <= port3_direction_ff[PIN_LAST:PIN_FIRST];
        end
    end

    assign rdata   = rdata_ff;
    assign p3_out  = p3_out_ff;
    assign p3_oe_n = p3_oe_n_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    // Cycles since the enable rose; zero in the cycle the enable first reads one
    int age_ff;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            age_ff <= 0;
        else if (!tone_output_enable)
            age_ff <= 0;
        else
            age_ff <= age_ff + 1;
    end

    property p_rsv_zero;
        @(posedge sys_clk) disable iff (!rstn) buzzer_control_ff[4:0] == 5'h00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("control low bits not zero");

    property p_byte_wr;
        @(posedge sys_clk) disable iff (!rstn)
        (ctrl_hit && req.wr_byte) |=> buzzer_control_ff == ($past(req.wdata) & CTRL_MASK);
    endproperty
    a_byte_wr: assert property (p_byte_wr) else $error("control byte write lost");

    property p_sel_bit_wr;
        @(posedge sys_clk) disable iff (!rstn)
        (ctrl_hit && req.wr_bit && !req.wr_byte && req.bit_sel == 3'h6)
            |=> tone_sel[1] == $past(req.wdata[0]) && $stable(buzzer_control_ff[EN_BIT]);
    endproperty
    a_sel_bit_wr: assert property (p_sel_bit_wr) else $error("select bit write wrong");

    property p_en_bit_wr;
        @(posedge sys_clk) disable iff (!rstn)
        (ctrl_hit && req.wr_bit && !req.wr_byte && req.bit_sel == 3'h7 && req.wdata[0] && !tone_output_enable)
            |=> tone_output_enable ##1 (age_ff == 1);
    endproperty
    a_en_bit_wr: assert property (p_en_bit_wr) else $error("enable bit did not start");

    property p_off_low;
        @(posedge sys_clk) disable iff (!rstn)
        !tone_output_enable |=> !tone_raw ##1 (p3_out_ff[TONE_PIN] == $past(port3_latch_ff[TONE_PIN]));
    endproperty
    a_off_low: assert property (p_off_low) else $error("tone not low while disabled");

    property p_rise_time;
        @(posedge sys_clk) disable iff (!rstn)
        $rose(tone_raw) |-> ((age_ff - 1) % (1 << period_log2(tone_sel))) == (1 << (period_log2(tone_sel) - 1));
    endproperty
    a_rise_time: assert property (p_rise_time) else $error("tone rise off period");

    property p_fall_time;
        @(posedge sys_clk) disable iff (!rstn)
        ($fell(tone_raw) && $past(tone_output_enable)) |-> ((age_ff - 1) % (1 << period_log2(tone_sel))) == 0;
    endproperty
    a_fall_time: assert property (p_fall_time) else $error("tone fall off period");

    property p_runs;
        @(posedge sys_clk) disable iff (!rstn)
        ($rose(tone_output_enable) && tone_sel == 2'h0) ##1 tone_output_enable[*8]
            |-> ##[505:505] (tone_raw || !tone_output_enable);
    endproperty
    a_runs: assert property (p_runs) else $error("tone did not appear");

    property p_pin_route;
        @(posedge sys_clk) disable iff (!rstn)
        (!port3_direction_ff[TONE_PIN] && !port3_latch_ff[TONE_PIN])
            |=> !p3_oe_n_ff[TONE_PIN] && p3_out_ff[TONE_PIN] == $past(tone_raw);
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("tone not routed to pin");

    property p_dir_wr;
        @(posedge sys_clk) disable iff (!rstn)
        (dir_hit && req.wr_byte) |=> port3_direction_ff == $past(req.wdata)
            ##1 p3_oe_n_ff[PIN_LAST:PIN_FIRST] == $past(port3_direction_ff[PIN_LAST:PIN_FIRST]);
    endproperty
    a_dir_wr: assert property (p_dir_wr) else $error("direction write wrong");

    property p_oe_fixed;
        @(posedge sys_clk) disable iff (!rstn) p3_oe_n_ff[0] && p3_oe_n_ff[7:5] == 3'h7;
    endproperty
    a_oe_fixed: assert property (p_oe_fixed) else $error("pin without buffer driven");

    c_tone_on: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(tone_raw));
    c_slow: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(tone_raw) && tone_sel == 2'h3);
    c_pin: cover property (@(posedge sys_clk) disable iff (!rstn) !p3_oe_n_ff[TONE_PIN] && p3_out_ff[TONE_PIN]);

endmodule

// ### tone_pkg.sv
// Shared constants, register map and request carrier of the buzzer tone block
package tone_pkg;

    // Register addresses
    localparam logic [15:0] CTRL_ADDR   = 16'hff40;
    localparam logic [15:0] DIR_ADDR    = 16'hff23;
    localparam logic [15:0] LATCH_ADDR  = 16'hff03;

    // Reset values
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [7:0]  DIR_RST     = 8'hff;
    localparam logic [7:0]  LATCH_RST   = 8'h00;

    // Control register field layout
    localparam int          EN_BIT      = 7;
    localparam int          SEL_HI_BIT  = 6;
    localparam int          SEL_LO_BIT  = 5;
    localparam logic [7:0]  CTRL_MASK   = 8'he0;

    // Port 3 layout
    localparam int          TONE_PIN    = 3;
    localparam int          PIN_FIRST   = 1;
    localparam int          PIN_LAST    = 4;

    // Divider: ratio is 2 to the power DIV_BASE plus the select code
    localparam int          DIV_BASE    = 10;
    localparam int          DIV_W       = 13;

    // CPU memory-manipulation request, bit writes carry their value in wdata[0]
    typedef struct packed {
        logic [15:0] addr;
        logic        wr_byte;
        logic        wr_bit;
        logic [2:0]  bit_sel;
        logic [7:0]  wdata;
        logic        rd;
    } cpu_req_t;

    // Log2 of the full tone period in clock cycles for a select code
    function automatic int period_log2(input logic [1:0] sel);
        period_log2 = DIV_BASE + int'(sel);
    endfunction

    // Next register value after a byte or single-bit write
    function automatic logic [7:0] apply_write(input logic [7:0] cur, input cpu_req_t req);
        logic [7:0] res;
        res = cur;
        if (req.wr_byte)
        begin
            res = req.wdata;
        end
        else if (req.wr_bit)
        begin
            res[req.bit_sel] = req.wdata[0];
        end
        apply_write = res;
    endfunction

endpackage

// ### tone_divider.sv
// Power-of-two clock divider producing the registered tone square wave
`timescale 1ns/1ps
module tone_divider
    import tone_pkg::*;
#(
    parameter int W = DIV_W
)
(
    input  wire logic       sys_clk,   // Peripheral clock
    input  wire logic       rstn,      // Asynchronous reset, active low
    input  wire logic       enable,    // Divider run
    input  wire logic [1:0] sel,       // Ratio select code
    output logic            tone       // Registered square wave
);

    logic [W-1:0] cnt_ff;
    logic         tone_ff;

    // Counter held at zero while stopped, so every enable starts a fresh period
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_ff <= '0;
        else if (enable)
            cnt_ff <= cnt_ff + 1'b1;
        else
            cnt_ff <= '0;
    end

    // The bit one below the period length flips every half period: 50 % duty
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            tone_ff <= 1'b0;
        else
            tone_ff <= enable & cnt_ff[period_log2(sel) - 1];
    end

    assign tone = tone_ff;

endmodule

// ### piezo_model.sv
// Behavioural piezo buzzer on port 3 pin 3 that measures the tone it hears
`timescale 1ns/1ps
module piezo_model
(
    input  wire logic sys_clk,     // Peripheral clock
    input  wire logic drive_lvl,   // Level driven by the port
    input  wire logic drive_oe_n,  // Port output enable, low drives
    output int        hi_len,      // Length of the last high run in cycles
    output int        lo_len,      // Length of the last low run in cycles
    output int        n_edges      // Count of pin transitions
);
    logic pin_q = 1'b0;
    logic pin;
    int   run   = 0;

    initial
    begin
        hi_len  = 0;
        lo_len  = 0;
        n_edges = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // A released pin has no pull, so it wanders rather than keep its level
    always @(posedge sys_clk)
    begin
        pin = drive_oe_n ? ~pin_q : drive_lvl;
        if (pin != pin_q)
        begin
            if (pin_q)
                hi_len <= run;
            else
                lo_len <= run;
            n_edges <= n_edges + 1;
            run     <= 1;
        end
        else
            run <= run + 1;
        pin_q <= pin;
    end
endmodule

// ### testbench.sv
// Self-checking bench for the buzzer tone output block
`timescale 1ns/1ps
module testbench
    import tone_pkg::*;
;
    typedef struct packed {
        logic [15:0] a;
        logic        wb;
        logic        wt;
        logic [2:0]  bs;
        logic [7:0]  d;
        logic [7:0]  exp;
        logic [7:0]  oe;
    } row_t;

    logic        sys_clk;
    logic        rstn;
    cpu_req_t    req;
    logic [7:0]  rdata;
    logic [7:0]  p3_out;
    logic [7:0]  p3_oe_n;
    logic [1:0]  sel;
    int          failures = 0;
    int          n_tests  = 0;
    int          hi_len;
    int          lo_len;
    int          n_edges;
    int          n;
    int          e0;
    int          half;
    row_t        rows [10] = '{
        '{CTRL_ADDR, 1'b1, 1'b0, 3'h0, 8'hff, 8'he0, 8'hff},
        '{CTRL_ADDR, 1'b0, 1'b1, 3'h2, 8'h01, 8'he0, 8'hff},
        '{CTRL_ADDR, 1'b0, 1'b1, 3'h7, 8'h00, 8'h60, 8'hff},
        '{CTRL_ADDR, 1'b1, 1'b0, 3'h0, 8'h40, 8'h40, 8'hff},
        '{CTRL_ADDR, 1'b1, 1'b0, 3'h0, 8'h00, 8'h00, 8'hff},
        '{DIR_ADDR,  1'b1, 1'b0, 3'h0, 8'h00, 8'h00, 8'he1},
        '{DIR_ADDR,  1'b0, 1'b1, 3'h3, 8'h01, 8'h08, 8'he9},
        '{16'hff80,  1'b1, 1'b0, 3'h0, 8'h5a, 8'h00, 8'he9},
        '{LATCH_ADDR, 1'b1, 1'b0, 3'h0, 8'h08, 8'h08, 8'he9},
        '{LATCH_ADDR, 1'b0, 1'b1, 3'h3, 8'h00, 8'h00, 8'he9}};

    tone_output dut (.sys_clk(sys_clk), .rstn(rstn), .req(req), .rdata(rdata), .p3_out(p3_out), .p3_oe_n(p3_oe_n));
    piezo_model buzzer (.sys_clk(sys_clk), .drive_lvl(p3_out[TONE_PIN]), .drive_oe_n(p3_oe_n[TONE_PIN]),
                        .hi_len(hi_len), .lo_len(lo_len), .n_edges(n_edges));

    ////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int lo, input int hi, input string what);
        n_tests++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("mismatch at %0t: %s got %0d expected %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    task automatic hang(input string what);
        failures++;
        $display("mismatch at %0t: timeout waiting for %s", $time, what);
        conclude();
    endtask

    // One request held for one cycle, released at the edge that takes it
    task automatic bus(input logic [15:0] a, input logic wb, input logic wt, input logic [2:0] bs,
                       input logic [7:0] d, input logic r);
        @(posedge sys_clk);
        req <= cpu_req_t'{addr: a, wr_byte: wb, wr_bit: wt, bit_sel: bs, wdata: d, rd: r};
        @(posedge sys_clk);
        req <= '0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        bus(a, 1'b0, 1'b0, 3'h0, 8'h00, 1'b1);
        @(negedge sys_clk);
        chk8(rdata, exp, "readback");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        req  = '0;
        repeat (12) @(posedge sys_clk);
        chk8(p3_oe_n, 8'hff, "oe in reset");
        rstn <= 1'b1;
        @(negedge sys_clk);
        chk8(p3_out, 8'h00, "pins after reset");
        rd_chk(CTRL_ADDR, 8'h00);
        rd_chk(DIR_ADDR, 8'hff);
        $display("test reset done");

        // Register table rows: write, read back, check port enables
        foreach (rows[i])
        begin
            bus(rows[i].a, rows[i].wb, rows[i].wt, rows[i].bs, rows[i].d, 1'b0);
            rd_chk(rows[i].a, rows[i].exp);
            chk8(p3_oe_n, rows[i].oe, "port enables");
        end
        $display("test registers done");

        // Latch levels reach every pin; a set pin 3 latch would mask the tone
        bus(LATCH_ADDR, 1'b1, 1'b0, 3'h0, 8'h16, 1'b0);
        repeat (2) @(negedge sys_clk);
        chk8(p3_out, 8'h16, "latch to pins");
        bus(LATCH_ADDR, 1'b1, 1'b0, 3'h0, 8'h00, 1'b0);
        $display("test latch done");

        // Route the tone to its pin, then every ratio in turn
        bus(DIR_ADDR, 1'b0, 1'b1, 3'h3, 8'h00, 1'b0);
        for (int s = 0; s < 4; s++)
        begin
            sel  = s[1:0];
            half = 1 << (DIV_BASE - 1 + s);
            bus(CTRL_ADDR, 1'b1, 1'b0, 3'h0, {1'b0, sel, 5'h00}, 1'b0);
            bus(CTRL_ADDR, 1'b0, 1'b1, 3'h7, 8'h01, 1'b0);
            n = 0;
            while (p3_out[TONE_PIN] !== 1'b1)
            begin
                @(negedge sys_clk);
                n++;
                if (n > 9000)
                    hang("tone rise");
            end
            chk_n(n, half, half + 4, "first rise");
            e0 = n_edges;
            n  = 0;
            // Rise, fall and rise again, so that both recorded runs lie inside the tone
            while (n_edges < e0 + 3)
            begin
                @(negedge sys_clk);
                n++;
                if (n > 3 * half)
                    hang("tone edges");
            end
            chk_n(hi_len, half, half, "high run");
            chk_n(lo_len, half, half, "low run");
            bus(CTRL_ADDR, 1'b0, 1'b1, 3'h7, 8'h00, 1'b0);
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            chk8({7'h00, p3_out[TONE_PIN]}, 8'h00, "stopped");
            repeat (half + 8) @(negedge sys_clk);
            chk8({7'h00, p3_out[TONE_PIN]}, 8'h00, "held low");
            $display("test tone select %0d done", s);
        end

        // Reset in mid tone: registers and pins fall back to their reset state
        bus(CTRL_ADDR, 1'b1, 1'b0, 3'h0, 8'h00, 1'b0);
        bus(CTRL_ADDR, 1'b0, 1'b1, 3'h7, 8'h01, 1'b0);
        repeat (600) @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk8(p3_oe_n, 8'hff, "oe in mid reset");
        chk8(p3_out, 8'h00, "pins in mid reset");
        rstn <= 1'b1;
        @(negedge sys_clk);
        chk8(p3_out, 8'h00, "pins after mid reset");
        rd_chk(CTRL_ADDR, 8'h00);
        rd_chk(DIR_ADDR, 8'hff);
        $display("test mid reset done");
        conclude();
    end
endmodule
